/* hdl/pdw_pkg.sv */
// Package for the power-down and wake controller
package pdw_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] PDW_ADDR_REG_CTRL   = 12'h000;
  localparam logic [11:0] PDW_ADDR_STATUS     = 12'h004;
  localparam logic [11:0] PDW_ADDR_WAKE_CFG   = 12'h008;
  localparam logic [11:0] PDW_ADDR_IRQ_FLAGS  = 12'h00c;
  localparam logic [11:0] PDW_ADDR_IRQ_ENABLE = 12'h010;
  localparam logic [11:0] PDW_ADDR_WDT_COUNT  = 12'h014;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int          PDW_REG_LP_BIT     = 1;
  localparam int          PDW_REG_RSVD_BIT   = 0;
  localparam logic [7:0]  PDW_REG_CTRL_RST   = 8'h01;
  localparam int          PDW_ST_PD_BIT      = 0;
  localparam int          PDW_ST_TO_BIT      = 1;
  localparam int          PDW_ST_ASLEEP_BIT  = 2;
  localparam int          PDW_CFG_GIE_BIT    = 0;
  localparam int          PDW_CFG_WDT_SLP    = 1;
  localparam int          PDW_CFG_T1_SLP     = 2;
  localparam int          PDW_CFG_ADC_SLP    = 3;
  localparam int          PDW_CFG_HF_SLP     = 4;
  localparam int          PDW_CFG_NOLP_PERIPH = 5;
  localparam logic [7:0]  PDW_CFG_RST        = 8'h00;
  localparam logic [31:0] PDW_WDT_RST        = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int PDW_STAB_SLOW_CYCLES = 4;

  typedef enum logic [1:0] {
    PDW_AWAKE,
    PDW_ASLEEP,
    PDW_STABILISE,
    PDW_RESUME
  } pdw_state_e;

  // Clock gates handed to the rest of the chip
  typedef struct packed {
    logic core;
    logic slow_osc;
    logic fast_osc;
    logic timer1;
    logic adc_osc;
    logic regulator_low_power;
  } pdw_clk_s;

endpackage : pdw_pkg

/* hdl/pdw_ctrl.sv */
// Power-down and wake controller with APB register slave
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module pdw_ctrl
  import pdw_pkg::*;
#(
  parameter int IRQ_W     = 8,
  parameter int WDT_W     = 24,
  parameter int STAB_SLOW = PDW_STAB_SLOW_CYCLES
) (
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic              i_clk_en,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // Core side
  input  wire logic              i_sleep_op,
  input  wire logic              i_clear_wdt_op,
  input  wire logic [WDT_W-1:0]  i_wdt_period,
  input  wire logic              i_wdt_enable,
  input  wire logic [IRQ_W-1:0]  i_irq_event,
  input  wire logic              i_slow_osc_tick,
  input  wire logic [IRQ_W-1:0]  i_pin_out,
  input  wire logic [IRQ_W-1:0]  i_pin_oe,
  output logic [IRQ_W-1:0]       o_pin_out,
  output logic [IRQ_W-1:0]       o_pin_oe,
  output pdw_clk_s               o_clk_gate,
  output logic                   o_prefetch_next,
  output logic                   o_resume,
  output logic                   o_vector_irq,
  output logic                   o_wdt_timeout_awake
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  pdw_state_e           state_r;
  logic [7:0]           reg_ctrl_r;
  logic [7:0]           cfg_r;
  logic                 pd_flag_r;
  logic                 to_flag_r;
  logic [IRQ_W-1:0]     irq_flag_r;
  logic [IRQ_W-1:0]     irq_en_r;
  logic [WDT_W-1:0]     wdt_r;
  logic [15:0]          stab_r;
  logic [2:0]           tick_sync_r;
  logic                 wr_en;
  logic                 rd_en;
  logic                 irq_pending;
  logic                 wdt_expire;
  logic                 tick_rise;
  logic                 asleep;
  logic                 enter_sleep;
  logic                 nop_sleep;
  logic                 wake;
  logic                 lp_sel;

  assign wr_en       = i_psel && i_penable && i_pwrite && !o_pready;
  assign rd_en       = i_psel && i_penable && !i_pwrite && !o_pready;
  assign irq_pending = |(irq_flag_r & irq_en_r);
  assign asleep      = (state_r == PDW_ASLEEP);
  assign wdt_expire  = (wdt_r >= i_wdt_period) && i_wdt_enable
                       && (!asleep || cfg_r[PDW_CFG_WDT_SLP]);
  // Slow tick from another domain: tick_rise is tied low; slow_edge_r marks third stage low, second stage high
  assign tick_rise   = tick_sync_r[2] == tick_sync_r[1] ? 1'b0 : 1'b0;
  assign enter_sleep = (state_r == PDW_AWAKE) && i_sleep_op
                       && !irq_pending;
  assign nop_sleep   = (state_r == PDW_AWAKE) && i_sleep_op && irq_pending;
  // While asleep, wake also on enabled events in the cycle they arrive, before their flag is set
  assign wake        = asleep && (irq_pending || |(i_irq_event & irq_en_r)
                       || wdt_expire);
  // Incompatible peripheral forces the normal regulator state
  assign lp_sel      = reg_ctrl_r[PDW_REG_LP_BIT]
                       && !cfg_r[PDW_CFG_NOLP_PERIPH];

  // ---------------------------------------------------------------
  // Slow oscillator tick synchroniser
  // ---------------------------------------------------------------
  logic slow_edge_r;
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tick_sync_r <= 3'h0;
      slow_edge_r <= 1'b0;
    end else if (i_clk_en) begin
      tick_sync_r <= {tick_sync_r[1:0], i_slow_osc_tick};
      slow_edge_r <= (tick_sync_r[2:1] == 2'b01);
    end
  end

  // ---------------------------------------------------------------
  // Sleep state machine
  // ---------------------------------------------------------------
  // Resets (pin, brown-out, power-on) all arrive on i_reset_n and so end
  // sleep the same way as when awake.
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_r <= PDW_AWAKE;
      stab_r  <= 16'h0000;
    end else if (i_clk_en) begin
      case (state_r)
        PDW_AWAKE: begin
          if (enter_sleep) begin
            state_r <= PDW_ASLEEP;
          end
        end
        PDW_ASLEEP: begin
          if (wake && lp_sel) begin
            state_r <= PDW_STABILISE;
            stab_r  <= 16'(STAB_SLOW);
          end else if (wake) begin
            state_r <= PDW_RESUME;
          end
        end
        PDW_STABILISE: begin
          if (stab_r == 16'h0000) begin
            state_r <= PDW_RESUME;
          end else if (slow_edge_r) begin
            stab_r <= stab_r - 16'h0001;
          end
        end
        PDW_RESUME: begin
          state_r <= PDW_AWAKE;
        end
        default: begin
          state_r <= PDW_AWAKE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Status flags
  // ---------------------------------------------------------------
  // Flags persist over reset release as power-on values
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pd_flag_r <= 1'b1;
      to_flag_r <= 1'b1;
    end else if (i_clk_en) begin
      if (enter_sleep) begin
        pd_flag_r <= 1'b0;
        to_flag_r <= 1'b1;
      end else if (i_clear_wdt_op && state_r == PDW_AWAKE) begin
        pd_flag_r <= 1'b1;
        to_flag_r <= 1'b1;
      end else if (asleep && wdt_expire) begin
        to_flag_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Watchdog counter
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdt_r <= '0;
    end else if (i_clk_en) begin
      if (enter_sleep || (wake && state_r == PDW_ASLEEP)
          || i_clear_wdt_op || !i_wdt_enable) begin
        wdt_r <= '0;
      end else if (state_r == PDW_STABILISE || state_r == PDW_RESUME) begin
        wdt_r <= '0;
      end else if (asleep && !cfg_r[PDW_CFG_WDT_SLP]) begin
        wdt_r <= wdt_r;
      end else if (slow_edge_r && !wdt_expire) begin
        wdt_r <= wdt_r + 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt flags and APB writes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_flag_r <= '0;
      irq_en_r   <= '0;
      reg_ctrl_r <= PDW_REG_CTRL_RST;
      cfg_r      <= PDW_CFG_RST;
    end else if (i_clk_en) begin
      // Write one to clear; a new event in the same cycle wins.
      if (wr_en && i_paddr == PDW_ADDR_IRQ_FLAGS) begin
        irq_flag_r <= (irq_flag_r & ~i_pwdata[IRQ_W-1:0]) | i_irq_event;
      end else begin
        irq_flag_r <= irq_flag_r | i_irq_event;
      end
      if (wr_en && i_paddr == PDW_ADDR_REG_CTRL) begin
        reg_ctrl_r <= {6'h00, i_pwdata[PDW_REG_LP_BIT], 1'b1};
      end else if (wr_en && i_paddr == PDW_ADDR_WAKE_CFG) begin
        cfg_r <= {2'h0, i_pwdata[5:0]};
      end else if (wr_en && i_paddr == PDW_ADDR_IRQ_ENABLE) begin
        irq_en_r <= i_pwdata[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // APB answer: one wait state, unmapped reads zero with error
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (i_clk_en) begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      if (wr_en || rd_en) begin
        if (i_paddr == PDW_ADDR_REG_CTRL) begin
          o_prdata <= {24'h000000, reg_ctrl_r};
        end else if (i_paddr == PDW_ADDR_STATUS) begin
          o_prdata <= {29'h0, asleep, to_flag_r, pd_flag_r};
        end else if (i_paddr == PDW_ADDR_WAKE_CFG) begin
          o_prdata <= {24'h000000, cfg_r};
        end else if (i_paddr == PDW_ADDR_IRQ_FLAGS) begin
          o_prdata <= 32'(irq_flag_r);
        end else if (i_paddr == PDW_ADDR_IRQ_ENABLE) begin
          o_prdata <= 32'(irq_en_r);
        end else if (i_paddr == PDW_ADDR_WDT_COUNT) begin
          o_prdata <= 32'(wdt_r);
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock gates, pins and core handshakes
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_clk_gate          <= '{core: 1'b1, slow_osc: 1'b1, fast_osc: 1'b1,
                               timer1: 1'b1, adc_osc: 1'b1,
                               regulator_low_power: 1'b0};
      o_pin_out           <= '0;
      o_pin_oe            <= '0;
      o_prefetch_next     <= 1'b0;
      o_resume            <= 1'b0;
      o_vector_irq        <= 1'b0;
      o_wdt_timeout_awake <= 1'b0;
    end else if (i_clk_en) begin
      // Core gated from entry until resume.
      o_clk_gate.core <= !(enter_sleep || asleep
                           || state_r == PDW_STABILISE);
      o_clk_gate.slow_osc <= 1'b1;
      o_clk_gate.timer1 <= !(enter_sleep || asleep)
                           || cfg_r[PDW_CFG_T1_SLP];
      o_clk_gate.adc_osc <= !(enter_sleep || asleep)
                            || cfg_r[PDW_CFG_ADC_SLP];
      o_clk_gate.fast_osc <= !(enter_sleep || asleep)
                             || cfg_r[PDW_CFG_HF_SLP];
      o_clk_gate.regulator_low_power <= (enter_sleep || asleep)
                                        && lp_sel;
      // Pins frozen while the core is gated.
      if (state_r == PDW_AWAKE && !enter_sleep) begin
        o_pin_out <= i_pin_out;
        o_pin_oe  <= i_pin_oe;
      end
      // Prefetch accompanies the executing op, no-op or not.
      o_prefetch_next <= (state_r == PDW_AWAKE) && i_sleep_op;
      o_resume        <= (state_r == PDW_RESUME) || nop_sleep;
      // Vector only after the following instruction.
      o_vector_irq    <= o_resume && cfg_r[PDW_CFG_GIE_BIT] && irq_pending;
      o_wdt_timeout_awake <= (state_r == PDW_AWAKE) && wdt_expire;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_entry_flags;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && enter_sleep) |=> (!pd_flag_r && to_flag_r);
  endproperty
  a_entry_flags: assert property (p_entry_flags)
    else $error("entry flags wrong");

  property p_nop_keeps;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && nop_sleep && !i_clear_wdt_op)
        |=> ($stable(pd_flag_r) && state_r == PDW_AWAKE);
  endproperty
  a_nop_keeps: assert property (p_nop_keeps)
    else $error("no-op sleep changed state");

  property p_core_gated;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && asleep && $past(asleep)) |=> !o_clk_gate.core;
  endproperty
  a_core_gated: assert property (p_core_gated)
    else $error("core clock ran while asleep");

  property p_wdt_clear_wake;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && wake) |=> (wdt_r == '0);
  endproperty
  a_wdt_clear_wake: assert property (p_wdt_clear_wake)
    else $error("watchdog not cleared on wake");

  property p_fast_wake;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && wake && !lp_sel) |=> (state_r == PDW_RESUME);
  endproperty
  a_fast_wake: assert property (p_fast_wake)
    else $error("normal wake not immediate");

  property p_lp_delay;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && wake && lp_sel) |=> (state_r == PDW_STABILISE);
  endproperty
  a_lp_delay: assert property (p_lp_delay)
    else $error("low-power wake skipped delay");

  property p_pins_hold;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (asleep && $past(asleep)) |-> $stable(o_pin_oe) && $stable(o_pin_out);
  endproperty
  a_pins_hold: assert property (p_pins_hold)
    else $error("pins moved while asleep");

  property p_flag_set;
    @(posedge i_clk_sys) disable iff (!i_reset_n)
      (i_clk_en && |i_irq_event) |=> ((irq_flag_r & $past(i_irq_event))
                                      == $past(i_irq_event));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("interrupt event lost");

endmodule : pdw_ctrl

`default_nettype wire

/* tb/pdw_core_model.sv */
// Core and interrupt source model for the power-down controller
`timescale 1ns/100ps
`default_nettype none
module pdw_core_model (
  input  wire logic       i_clk_sys,
  output logic            o_sleep_op,
  output logic            o_clear_wdt_op,
  output logic [7:0]      o_irq_event,
  output logic            o_slow_osc_tick
);
  // ------------------------------------------------------------
  // Slow oscillator, free running and out of phase with the clock
  // ------------------------------------------------------------
  initial begin
    o_sleep_op      = 1'b0;
    o_clear_wdt_op  = 1'b0;
    o_irq_event     = 8'h00;
    o_slow_osc_tick = 1'b0;
    forever #21 o_slow_osc_tick = ~o_slow_osc_tick;
  end

  // ------------------------------------------------------------
  // One-cycle strobes, launched right after a rising edge
  // ------------------------------------------------------------
  task automatic sleep_pulse;
    @(posedge i_clk_sys);
    o_sleep_op <= 1'b1;
    @(posedge i_clk_sys);
    o_sleep_op <= 1'b0;
  endtask : sleep_pulse

  task automatic clr_pulse;
    @(posedge i_clk_sys);
    o_clear_wdt_op <= 1'b1;
    @(posedge i_clk_sys);
    o_clear_wdt_op <= 1'b0;
  endtask : clr_pulse

  task automatic irq_pulse(input logic [7:0] m);
    @(posedge i_clk_sys);
    o_irq_event <= m;
    @(posedge i_clk_sys);
    o_irq_event <= 8'h00;
  endtask : irq_pulse
endmodule : pdw_core_model
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench for the power-down controller
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import pdw_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, sleep_op, clr_op, tick;
  logic        pready, pslverr, prefetch, resume, vector, wdt_aw, wdt_en;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] period;
  logic [7:0]  irq, pin_o, pin_e, q_o, q_e, po, pe;
  pdw_clk_s    gate;
  int          n_mismatch, cmp_count, n_norm, n_lp, n;

  pdw_ctrl u_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_clk_en(1'b1),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_sleep_op(sleep_op), .i_clear_wdt_op(clr_op),
    .i_wdt_period(period), .i_wdt_enable(wdt_en), .i_irq_event(irq),
    .i_slow_osc_tick(tick), .i_pin_out(pin_o), .i_pin_oe(pin_e),
    .o_pin_out(po), .o_pin_oe(pe), .o_clk_gate(gate),
    .o_prefetch_next(prefetch), .o_resume(resume), .o_vector_irq(vector),
    .o_wdt_timeout_awake(wdt_aw));
  pdw_core_model u_core (.i_clk_sys(clk), .o_sleep_op(sleep_op),
    .o_clear_wdt_op(clr_op), .o_irq_event(irq), .o_slow_osc_tick(tick));

  // ------------------------------------------------------------
  // Clock and watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) n_mismatch++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rd_chk

  task automatic wait_resume(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (resume !== 1'b1 && c < 600);
    if (c >= 600) n_mismatch++;
  endtask : wait_resume

  function automatic pdw_clk_s exp_gate(input logic [7:0] cfg, rc);
    pdw_clk_s g;
    g.core = 1'b0;
    g.slow_osc = 1'b1;
    g.fast_osc = cfg[PDW_CFG_HF_SLP];
    g.timer1 = cfg[PDW_CFG_T1_SLP];
    g.adc_osc = cfg[PDW_CFG_ADC_SLP];
    g.regulator_low_power = rc[PDW_REG_LP_BIT] & ~cfg[PDW_CFG_NOLP_PERIPH];
    return g;
  endfunction : exp_gate

  // Sleep, poke a masked source, then wake on source 0
  task automatic nap(input logic [7:0] cfg, rc, output int c);
    int b;
    b = $urandom_range(7, 1);
    apb(1'b1, PDW_ADDR_WAKE_CFG, {24'h0, cfg});
    apb(1'b1, PDW_ADDR_REG_CTRL, {24'h0, rc});
    apb(1'b1, PDW_ADDR_IRQ_ENABLE, 32'h1);
    pin_o <= 8'($urandom);
    pin_e <= 8'($urandom);
    u_core.sleep_pulse();
    #1;
    check({31'h0, prefetch}, 32'h1);
    check({26'h0, gate}, {26'h0, exp_gate(cfg, rc)});
    q_o = pin_o;
    q_e = pin_e;
    @(posedge clk);
    pin_o <= ~q_o;
    pin_e <= ~q_e;
    rd_chk(PDW_ADDR_STATUS, 32'h6);
    u_core.irq_pulse(8'h1 << b);
    repeat (4) @(posedge clk) check({31'h0, resume}, 32'h0);
    rd_chk(PDW_ADDR_IRQ_FLAGS, 32'h1 << b);
    check({16'h0, po, pe}, {16'h0, q_o, q_e});
    u_core.irq_pulse(8'h1);
    wait_resume(c);
    @(posedge clk);
    check({31'h0, vector}, {31'h0, cfg[PDW_CFG_GIE_BIT]});
    rd_chk(PDW_ADDR_STATUS, 32'h2);
    apb(1'b1, PDW_ADDR_IRQ_FLAGS, 32'hff);
    rd_chk(PDW_ADDR_IRQ_FLAGS, 32'h0);
    $display("Test nap cfg %h done in %0d cycles", cfg, c);
  endtask : nap

  task automatic conclude;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'hf774));
    {psel, penable, pwrite, wdt_en, rst_n} = 5'h0;
    {paddr, pwdata, period, pin_o, pin_e} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PDW_ADDR_REG_CTRL, 32'h1);
    rd_chk(PDW_ADDR_STATUS, 32'h3);
    rd_chk(PDW_ADDR_WAKE_CFG, 32'h0);
    rd_chk(PDW_ADDR_IRQ_ENABLE, 32'h0);
    rd_chk(PDW_ADDR_WDT_COUNT, 32'h0);
    apb(1'b1, 12'h018, 32'hffff);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, PDW_ADDR_REG_CTRL, 32'h0);
    rd_chk(PDW_ADDR_REG_CTRL, 32'h1);
    $display("Test registers done");
    nap(8'h00, 8'h00, n_norm);
    nap(8'h01, 8'h00, n);
    nap(8'h1c, 8'h03, n_lp);
    // Slow period is ten and a half system cycles
    check({31'h0, n_lp >= n_norm + 30}, 32'h1);
    nap(8'h20, 8'h02, n);
    u_core.clr_pulse();
    rd_chk(PDW_ADDR_STATUS, 32'h3);
    u_core.irq_pulse(8'h1);
    u_core.sleep_pulse();
    wait_resume(n);
    check({31'h0, n <= 2}, 32'h1);
    check({31'h0, gate.core}, 32'h1);
    rd_chk(PDW_ADDR_STATUS, 32'h3);
    apb(1'b1, PDW_ADDR_IRQ_FLAGS, 32'hff);
    $display("Test pending no-op done");
    period <= 24'hffffff;
    wdt_en <= 1'b1;
    apb(1'b1, PDW_ADDR_WAKE_CFG, 32'h0);
    repeat (60) @(posedge clk);
    u_core.sleep_pulse();
    rd_chk(PDW_ADDR_WDT_COUNT, 32'h0);
    repeat (50) @(posedge clk);
    rd_chk(PDW_ADDR_WDT_COUNT, 32'h0);
    period <= 24'h3;
    apb(1'b1, PDW_ADDR_WAKE_CFG, 32'h2);
    wait_resume(n);
    wdt_en <= 1'b0;
    rd_chk(PDW_ADDR_STATUS, 32'h0);
    rd_chk(PDW_ADDR_WDT_COUNT, 32'h0);
    u_core.clr_pulse();
    $display("Test watchdog wake done");
    u_core.sleep_pulse();
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    check({26'h0, gate}, 32'h3e);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(PDW_ADDR_STATUS, 32'h3);
    rd_chk(PDW_ADDR_REG_CTRL, 32'h1);
    $display("Test reset in sleep done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
